// ### rtl/aps_pkg.sv
// constants, field layouts and carriers of the auxiliary port / slave port block
// assumes one 125 MHz clock, synchronous active-high reset, avalon-mm register access
package aps_pkg;

  // =====================================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] REG_DATA_PORT    = 8'h08;
  localparam logic [7:0] REG_AUX_PINS     = 8'h09;
  localparam logic [7:0] REG_IRQ_STATUS   = 8'h0C;
  localparam logic [7:0] REG_AUX_DIR_STAT = 8'h89;
  localparam logic [7:0] REG_IRQ_MASK     = 8'h8C;
  localparam logic [7:0] REG_ANALOG_CFG   = 8'h9F;

  // =====================================================================
  // field positions of the direction/status register; BIT_IRQ_SLAVE is bit 0 of the irq status and mask registers
  localparam int BIT_INPUT_FULL   = 7;
  localparam int BIT_OUTPUT_FULL  = 6;
  localparam int BIT_OVERFLOW     = 5;
  localparam int BIT_SLAVE_SELECT = 4;
  localparam int BIT_IRQ_SLAVE    = 0;

  // =====================================================================
  // reset values
  localparam logic [2:0] RST_DIRECTION  = 3'h7;
  localparam logic [2:0] RST_ANALOG_CFG = 3'h0;
  localparam logic [2:0] RST_PIN_LATCH  = 3'h0;
  localparam logic [7:0] RST_DATA_LATCH = 8'h00;
  // pin_config_field values with both upper bits set make the pins digital
  localparam logic [1:0] CFG_DIGITAL_HI = 2'h3;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic rd_n;
  } aps_strobe_s;

endpackage

// ### rtl/aps_top.sv
// auxiliary three-pin port with parallel slave port control and status
// assumes pins are asynchronous to ref_clk; registers reached over avalon-mm
module aps_top
  import aps_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic [2:0]  aux_pin_in,
  output logic      [2:0]  aux_pin_out,
  output logic      [2:0]  aux_pin_oe_n,
  input  wire logic [7:0]  data_bus_in,
  output logic      [7:0]  data_bus_out,
  output logic      [7:0]  data_bus_oe_n
);

  // =====================================================================
  // pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [2:0]  pin_s1_ff;
  logic [2:0]  pin_s2_ff;
  logic [2:0]  pin_s3_ff;
  logic [2:0]  pin_filt_ff;
  logic [7:0]  bus_s1_ff;
  logic [7:0]  bus_s2_ff;
  logic [7:0]  bus_s3_ff;
  logic [7:0]  bus_filt_ff;

  always_ff @(posedge ref_clk) begin
    pin_s1_ff <= aux_pin_in;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
    bus_s1_ff <= data_bus_in;
    bus_s2_ff <= bus_s1_ff;
    bus_s3_ff <= bus_s2_ff;
  end

  // strobes start deasserted so reset never fakes a cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_filt_ff <= 3'h7;
      bus_filt_ff <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_filt_ff[i] <= pin_s3_ff[i];
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (bus_s2_ff[i] == bus_s3_ff[i]) begin
          bus_filt_ff[i] <= bus_s3_ff[i];
        end
      end
    end
  end

  // =====================================================================
  // state
  logic [2:0]  direction_ff;
  logic        slave_port_select_ff;
  logic        input_full_flag_ff;
  logic        output_full_flag_ff;
  logic        input_overflow_flag_ff;
  logic [2:0]  pin_config_field_ff;
  logic [2:0]  pin_latch_ff;
  logic [7:0]  out_latch_ff;
  logic [7:0]  in_latch_ff;
  logic        slave_port_irq_flag_ff;
  logic        irq_enable_ff;
  logic        wr_act_ff;
  logic        rd_act_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;
  logic [2:0]  pin_out_ff;
  logic [2:0]  pin_oe_n_ff;
  logic [7:0]  bus_out_ff;
  logic [7:0]  bus_oe_n_ff;

  // =====================================================================
  // slave port cycle detection
  aps_strobe_s strobe;
  wire         pins_digital = (pin_config_field_ff[2:1] == CFG_DIGITAL_HI);
  wire  [2:0]  analog_mask  = pins_digital ? 3'h0 : 3'h7;
  assign strobe = aps_strobe_s'(pin_filt_ff);

  // select high masks both strobes
  wire wr_act    = slave_port_select_ff && !strobe.sel_n && !strobe.wr_n;
  wire rd_act    = slave_port_select_ff && !strobe.sel_n && !strobe.rd_n;
  wire wr_done   = wr_act_ff && !wr_act;
  wire rd_start  = rd_act && !rd_act_ff;
  wire rd_done   = rd_act_ff && !rd_act;

  // =====================================================================
  // avalon-mm slave: one wait cycle, then one cycle with waitrequest low
  wire       req      = avs_read || avs_write;
  wire       accept   = req && !wait_ff;
  wire [7:0] reg_idx  = avs_address[9:2];
  wire       lane0    = avs_byteenable[0];
  wire       wr_ok    = accept && avs_write && lane0;

  wire sel_data   = (reg_idx == REG_DATA_PORT);
  wire sel_pins   = (reg_idx == REG_AUX_PINS);
  wire sel_istat  = (reg_idx == REG_IRQ_STATUS);
  wire sel_dir    = (reg_idx == REG_AUX_DIR_STAT);
  wire sel_imask  = (reg_idx == REG_IRQ_MASK);
  wire sel_acfg   = (reg_idx == REG_ANALOG_CFG);

  wire       wr_data  = wr_ok && sel_data;
  wire       wr_pins  = wr_ok && sel_pins;
  wire       wr_istat = wr_ok && sel_istat;
  wire       wr_dir   = wr_ok && sel_dir;
  wire       wr_imask = wr_ok && sel_imask;
  wire       wr_acfg  = wr_ok && sel_acfg;
  wire       rd_data  = accept && avs_read && sel_data;
  wire [7:0] wdat     = avs_writedata[7:0];

  wire [7:0] dir_stat_view = {input_full_flag_ff, output_full_flag_ff,
                              input_overflow_flag_ff, slave_port_select_ff,
                              1'b0, direction_ff};
  wire [7:0] pins_view     = {5'h00, pin_filt_ff & ~analog_mask};

  logic [7:0] rd_mux;
  always_comb begin
    if (sel_data) begin
      rd_mux = in_latch_ff;
    end else if (sel_pins) begin
      rd_mux = pins_view;
    end else if (sel_istat) begin
      rd_mux = {7'h00, slave_port_irq_flag_ff};
    end else if (sel_dir) begin
      rd_mux = dir_stat_view;
    end else if (sel_imask) begin
      rd_mux = {7'h00, irq_enable_ff};
    end else if (sel_acfg) begin
      rd_mux = {5'h00, pin_config_field_ff};
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= !(req && wait_ff);
      if (req && wait_ff) begin
        rdata_ff <= {24'h00_0000, rd_mux};
      end
    end
  end

  // =====================================================================
  // control registers written by software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      direction_ff         <= RST_DIRECTION;
      slave_port_select_ff <= 1'b0;
      pin_config_field_ff  <= RST_ANALOG_CFG;
      pin_latch_ff         <= RST_PIN_LATCH;
      out_latch_ff         <= RST_DATA_LATCH;
      irq_enable_ff        <= 1'b0;
    end else begin
      if (wr_dir) begin
        direction_ff         <= wdat[2:0];
        slave_port_select_ff <= wdat[BIT_SLAVE_SELECT];
      end
      if (wr_acfg) begin
        pin_config_field_ff <= wdat[2:0];
      end
      if (wr_pins) begin
        pin_latch_ff <= wdat[2:0];
      end
      if (wr_data) begin
        out_latch_ff <= wdat;
      end
      if (wr_imask) begin
        irq_enable_ff <= wdat[BIT_IRQ_SLAVE];
      end
    end
  end

  // =====================================================================
  // slave port flags; hardware set wins over software clear
  wire nxt_input_full  = slave_port_select_ff && (wr_done || (input_full_flag_ff && !rd_data));
  wire nxt_output_full = slave_port_select_ff && !rd_start && (wr_data || output_full_flag_ff);
  wire nxt_overflow    = (wr_done && input_full_flag_ff) ||
                         (input_overflow_flag_ff && !(wr_dir && !wdat[BIT_OVERFLOW]));
  wire nxt_irq_flag    = wr_done || rd_done ||
                         (slave_port_irq_flag_ff && !(wr_istat && wdat[BIT_IRQ_SLAVE]));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_full_flag_ff     <= 1'b0;
      output_full_flag_ff    <= 1'b0;
      input_overflow_flag_ff <= 1'b0;
      slave_port_irq_flag_ff <= 1'b0;
      in_latch_ff            <= RST_DATA_LATCH;
      wr_act_ff              <= 1'b0;
      rd_act_ff              <= 1'b0;
    end else begin
      input_full_flag_ff     <= nxt_input_full;
      output_full_flag_ff    <= nxt_output_full;
      input_overflow_flag_ff <= nxt_overflow;
      slave_port_irq_flag_ff <= nxt_irq_flag;
      wr_act_ff              <= wr_act;
      rd_act_ff              <= rd_act;
      // keep following the bus while the write strobe is held, so the last
      // stable byte before the strobe rises is what stays in the latch
      if (wr_act) begin
        in_latch_ff <= bus_filt_ff;
      end
    end
  end

  // =====================================================================
  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ff      <= 1'b0;
      pin_out_ff  <= RST_PIN_LATCH;
      pin_oe_n_ff <= RST_DIRECTION;
      bus_out_ff  <= RST_DATA_LATCH;
      bus_oe_n_ff <= 8'hFF;
    end else begin
      irq_ff      <= slave_port_irq_flag_ff && irq_enable_ff;
      pin_out_ff  <= pin_latch_ff;
      // analog mode does not override direction, software must keep inputs
      pin_oe_n_ff <= direction_ff;
      bus_out_ff  <= out_latch_ff;
      bus_oe_n_ff <= rd_act ? 8'h00 : 8'hFF;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq             = irq_ff;
  assign aux_pin_out     = pin_out_ff;
  assign aux_pin_oe_n    = pin_oe_n_ff;
  assign data_bus_out    = bus_out_ff;
  assign data_bus_oe_n   = bus_oe_n_ff;

endmodule

// ### sim/aps_ext_cpu.sv
// external 8-bit cpu model driving the slave strobes and data bus
// assumes the bench resolves the pins with the block's own enables
module aps_ext_cpu
  import aps_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] data_bus_out,
  input  wire logic [7:0] data_bus_oe_n,
  output logic      [2:0] pins,
  output logic      [7:0] data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  aps_strobe_s strb;
  assign pins = strb;
  initial begin
    strb = 3'h7;
    data_bus_in = 8'h00;
  end
  // ==========================================
  // one strobe cycle, held 8 clocks so the sync filter sees it
  task automatic cycle(input logic rd, input logic sel, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge ref_clk);
    strb.sel_n <= sel;
    strb.rd_n <= !rd;
    strb.wr_n <= rd;
    data_bus_in <= rd ? ~d : d;
    repeat (8) @(posedge ref_clk);
    q = (data_bus_oe_n === 8'h00) ? data_bus_out : 8'hxx;
    strb <= 3'h7;
    repeat (8) @(posedge ref_clk);
    // released bus has no pull: show the inverse, not the old byte
    data_bus_in <= ~data_bus_in;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// ### sim/aps_top_chk.sv
// port assertions of the auxiliary / slave port block
// assumes only the top ports; one clock, synchronous reset
module aps_top_chk
  import aps_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  input wire logic [2:0]  aux_pin_in,
  input wire logic [2:0]  aux_pin_oe_n,
  input wire logic [7:0]  data_bus_oe_n
);
  // ==========================================
  // handshake and pins
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; avs_read && !avs_waitrequest; endsequence
  a_wait_one: assert property (s_req |=> !avs_waitrequest) else $error("wait not one");
  a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low");
  a_reset_vals: assert property (
    @(posedge ref_clk) disable iff (1'b0) rst |=> aux_pin_oe_n == 3'h7
    && data_bus_oe_n == 8'hff && !irq) else $error("reset outputs");
  a_oe_cause: assert property (
    !$past(rst) && $changed(aux_pin_oe_n) |-> $past(avs_write) || $past(avs_write, 2)
    || $past(avs_write, 3)) else $error("oe change without write");
  a_cs_ignore: assert property (
    aux_pin_in[2] [*8] |=> data_bus_oe_n == 8'hff) else $error("driven unselected");
  a_rd_idle: assert property (
    aux_pin_in[0] [*8] |=> data_bus_oe_n == 8'hff) else $error("driven without read");
  a_bus_whole: assert property (
    data_bus_oe_n == 8'h00 || data_bus_oe_n == 8'hff) else $error("partial drive");
  a_bit3_zero: assert property (
    s_ans and avs_address[9:2] == REG_AUX_DIR_STAT |-> !avs_readdata[3])
    else $error("bit 3 set");
  a_pins_upper: assert property (
    s_ans and avs_address[9:2] == REG_AUX_PINS |-> avs_readdata[7:3] == 5'h0)
    else $error("pin upper bits");
endmodule

bind aps_top aps_top_chk u_chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .aux_pin_in(aux_pin_in),
  .aux_pin_oe_n(aux_pin_oe_n), .data_bus_oe_n(data_bus_oe_n));

// ### sim/aps_top_test.sv
// self-checking bench of aps_top, random values under a fixed seed
// assumes the cpu model drives the slave pins and data bus
module aps_top_test
  import aps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, avs_read, avs_write, irq, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [2:0]  aux_pin_in, aux_pin_out, aux_pin_oe_n, cpu_pins, cf;
  logic [7:0]  data_bus_in, data_bus_out, data_bus_oe_n, q, b, c;
  int          fails, checks_done;
  always #4 ref_clk = ~ref_clk;
  // a pin reads what drives it: the block when enabled, else the cpu
  assign aux_pin_in = (aux_pin_out & ~aux_pin_oe_n) | (cpu_pins & aux_pin_oe_n);
  aps_top uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .aux_pin_in(aux_pin_in),
    .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n));
  aps_ext_cpu cpu (.ref_clk(ref_clk), .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n), .pins(cpu_pins), .data_bus_in(data_bus_in));
  // ==========================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] rd);
    int n;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    // request stands until waitrequest is seen low at a rising edge
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) begin
        break;
      end
    end
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(what, exp, v);
  endtask
  function automatic logic [7:0] stat(input logic in_full, out_full, ov, md);
    return {in_full, out_full, ov, md, 4'h7};
  endfunction
  function automatic logic [7:0] pins_exp(input logic [2:0] cfg, dir, out);
    return (cfg[2:1] == CFG_DIGITAL_HI) ? {5'h0, (out & ~dir) | dir} : 8'h00;
  endfunction
  // ==========================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    fails = 0;
    checks_done = 0;
    void'($urandom(71831));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk("dir_stat", REG_AUX_DIR_STAT, 8'h07);
    rd_chk("analog_cfg", REG_ANALOG_CFG, 8'h00);
    rd_chk("unmapped", 8'h50, 8'h00);
    // a write without the low byte lane must leave the register alone
    avs_byteenable <= 4'he;
    bus(1'b1, REG_ANALOG_CFG, 8'h07, q);
    avs_byteenable <= 4'hf;
    rd_chk("analog_cfg", REG_ANALOG_CFG, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom);
      cf = i[0] ? 3'h6 : c[7:5];
      bus(1'b1, REG_ANALOG_CFG, {5'h0, cf}, q);
      bus(1'b1, REG_AUX_DIR_STAT, {5'h0, c[2:0]}, q);
      bus(1'b1, REG_AUX_PINS, {5'h0, c[5:3]}, q);
      repeat (5) @(posedge ref_clk);
      chk("oe_n", {5'h0, c[2:0]}, {5'h0, aux_pin_oe_n});
      chk("pin_out", {5'h0, c[5:3]}, {5'h0, aux_pin_out});
      rd_chk("pins", REG_AUX_PINS, pins_exp(cf, c[2:0], c[5:3]));
    end
    bus(1'b1, REG_ANALOG_CFG, 8'h06, q);
    // pins must be inputs and settled high before slave mode, else a fake cycle
    bus(1'b1, REG_AUX_DIR_STAT, 8'h07, q);
    repeat (8) @(posedge ref_clk);
    bus(1'b1, REG_AUX_DIR_STAT, 8'h17, q);
    b = 8'($urandom);
    cpu.cycle(1'b0, 1'b0, b, q);
    chk("irq_masked", 8'h00, {7'h0, irq});
    rd_chk("irq_stat", REG_IRQ_STATUS, 8'h01);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(1, 0, 0, 1));
    bus(1'b1, REG_IRQ_MASK, 8'h01, q);
    repeat (3) @(posedge ref_clk);
    chk("irq_on", 8'h01, {7'h0, irq});
    bus(1'b1, REG_IRQ_STATUS, 8'h01, q);
    repeat (3) @(posedge ref_clk);
    chk("irq_clear", 8'h00, {7'h0, irq});
    rd_chk("in_latch", REG_DATA_PORT, b);
    cpu.cycle(1'b0, 1'b1, ~b, q);
    cpu.cycle(1'b1, 1'b1, ~b, q);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(0, 0, 0, 1));
    c = 8'($urandom);
    cpu.cycle(1'b0, 1'b0, b, q);
    cpu.cycle(1'b0, 1'b0, c, q);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(1, 0, 1, 1));
    bus(1'b1, REG_AUX_DIR_STAT, 8'h27, q);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(0, 0, 1, 0));
    rd_chk("in_latch", REG_DATA_PORT, c);
    bus(1'b1, REG_AUX_DIR_STAT, 8'h17, q);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(0, 0, 0, 1));
    bus(1'b1, REG_DATA_PORT, c, q);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(0, 1, 0, 1));
    cpu.cycle(1'b1, 1'b0, 8'h00, q);
    chk("ext_read", c, q);
    rd_chk("dir_stat", REG_AUX_DIR_STAT, stat(0, 0, 0, 1));
    // second reset in mid-run must restore the same values
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk("dir_stat", REG_AUX_DIR_STAT, 8'h07);
    rd_chk("irq_stat", REG_IRQ_STATUS, 8'h00);
    chk("irq_reset", 8'h00, {7'h0, irq});
    tally_and_finish();
  end
endmodule
